// ==== rtl/smta_cfg.svh ====
// address map, field positions and sizes of the table access registers
`ifndef SMTA_CFG_SVH
`define SMTA_CFG_SVH

`define SMTA_ADDR_W      16
`define SMTA_CTRL_OFS    16'h041C
`define SMTA_ENT1_OFS    16'h0420
`define SMTA_ENT2_OFS    16'h0424
`define SMTA_ENT3_OFS    16'h0428
`define SMTA_ENT4_OFS    16'h042C
`define SMTA_ENT_BASE    16'h0420
`define SMTA_ENT_MASK    16'hFFF3
`define SMTA_ENT_LSB     2
`define SMTA_ENT_MSB     3
`define SMTA_IDX_MSB     21
`define SMTA_IDX_LSB     16
`define SMTA_ST_IDX_MSB  19
`define SMTA_GO_BIT      7
`define SMTA_RSV_MSB     6
`define SMTA_RSV_LSB     2
`define SMTA_SEL_BIT     1
`define SMTA_DIR_BIT     0
`define SMTA_IDX_W       6
`define SMTA_ST_IDX_W    4
`define SMTA_RSV_W       5
`define SMTA_WORDS       4
`define SMTA_MC_WORD     1
`define SMTA_ST_DEPTH    16
`define SMTA_MC_DEPTH    64
`define SMTA_SEL_MC      1'b1
`define SMTA_DIR_READ    1'b1

`endif

// ==== rtl/smta_pkg.sv ====
// types shared by the table access logic
package smta_pkg;
  typedef enum logic [0:0] {
    SMTA_IDLE,
    SMTA_EXEC
  } smta_state_t;
  typedef logic [31:0] smta_word_t;
endpackage

// ==== rtl/smta_top.sv ====
// indirect access control for the static and reserved multicast tables
`timescale 1ns/10ps
`default_nettype none
`include "smta_cfg.svh"

// Function
// - control register sits at byte offset 0x041C with index, select, direction, go
// - multicast table uses index bits 21:16 as entry number
// - static table uses index bits 19:16, sixteen entries
// - software sets bit 7 to start; hardware clears it when done
// - bit 1 selects table: one multicast, zero static
// - bit 0 direction: one table to entry regs, zero entry regs to table
// - static accesses move data through all four entry words 0x0420-0x042C
// - multicast accesses use only entry word at 0x0424
// - entry word meaning depends on the table selected
module smta_top #(
  parameter int ST_DEPTH = `SMTA_ST_DEPTH,
  parameter int MC_DEPTH = `SMTA_MC_DEPTH
) (
  // clock, reset, enable
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    ce_i,
  // register port
  input  wire logic [`SMTA_ADDR_W-1:0] reg_addr_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic [31:0]             reg_wdata_i,
  output logic      [31:0]             reg_rdata_o,
  output logic                         reg_rvalid_o,
  // status
  output logic                         busy_o
);

  smta_pkg::smta_state_t state_q, state_d;
  logic [`SMTA_IDX_W-1:0] idx_q, idx_d;
  logic [`SMTA_RSV_W-1:0] rsv_q, rsv_d;
  logic                   go_q, go_d;
  logic                   sel_q, sel_d;
  logic                   dir_q, dir_d;
  smta_pkg::smta_word_t   ent_q [`SMTA_WORDS];
  smta_pkg::smta_word_t   ent_d [`SMTA_WORDS];
  logic [31:0]            rdata_q, rdata_d;
  logic                   rvalid_q, rvalid_d;
  logic                   st_we, mc_we;
  logic [127:0]           st_mem [ST_DEPTH];
  logic [31:0]            mc_mem [MC_DEPTH];
  logic [127:0]           st_row;
  logic [31:0]            mc_row;
  logic [`SMTA_ST_IDX_W-1:0] st_idx;
  logic [`SMTA_IDX_W-1:0]    mc_idx;
  logic                   wr_ok;
  logic [2:0]             wr_ent, rd_ent;

  // entry word decode: bit 2 hit, bits 1:0 word number
  function automatic logic [2:0] ent_dec(input logic [`SMTA_ADDR_W-1:0] a);
    logic hit;
    hit = ((a & `SMTA_ENT_MASK) == `SMTA_ENT_BASE);
    return {hit, a[`SMTA_ENT_MSB:`SMTA_ENT_LSB]};
  endfunction

  function automatic logic [31:0] ctrl_word(input logic [5:0] ix,
                                            input logic g,
                                            input logic [4:0] r,
                                            input logic s,
                                            input logic d);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`SMTA_IDX_MSB:`SMTA_IDX_LSB] = ix;
    w[`SMTA_GO_BIT] = g;
    w[`SMTA_RSV_MSB:`SMTA_RSV_LSB] = r;
    w[`SMTA_SEL_BIT] = s;
    w[`SMTA_DIR_BIT] = d;
    return w;
  endfunction

  assign st_idx = idx_q[`SMTA_ST_IDX_W-1:0];
  assign mc_idx = idx_q;
  assign st_row = st_mem[st_idx];
  assign mc_row = mc_mem[mc_idx];
  assign wr_ok  = reg_wr_i && !go_q && (state_q == smta_pkg::SMTA_IDLE);
  assign wr_ent = ent_dec(reg_addr_i);
  assign rd_ent = ent_dec(reg_addr_i);

  always_comb begin
    state_d  = state_q;
    idx_d    = idx_q;
    rsv_d    = rsv_q;
    go_d     = go_q;
    sel_d    = sel_q;
    dir_d    = dir_q;
    ent_d    = ent_q;
    st_we    = 1'b0;
    mc_we    = 1'b0;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    // software writes, ignored while an access is in flight
    if (wr_ok) begin
      if (reg_addr_i == `SMTA_CTRL_OFS) begin
        idx_d = reg_wdata_i[`SMTA_IDX_MSB:`SMTA_IDX_LSB];
        go_d  = reg_wdata_i[`SMTA_GO_BIT];
        rsv_d = reg_wdata_i[`SMTA_RSV_MSB:`SMTA_RSV_LSB];
        sel_d = reg_wdata_i[`SMTA_SEL_BIT];
        dir_d = reg_wdata_i[`SMTA_DIR_BIT];
      end else if (wr_ent[2]) begin
        ent_d[wr_ent[1:0]] = reg_wdata_i;
      end
    end
    // register reads; unmapped addresses read zero
    if (reg_rd_i) begin
      rvalid_d = 1'b1;
      if (reg_addr_i == `SMTA_CTRL_OFS) begin
        rdata_d = ctrl_word(idx_q, go_q, rsv_q, sel_q, dir_q);
      end else if (rd_ent[2]) begin
        rdata_d = ent_q[rd_ent[1:0]];
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
    unique case (state_q)
      smta_pkg::SMTA_IDLE: begin
        if (go_q) begin
          state_d = smta_pkg::SMTA_EXEC;
        end
      end
      smta_pkg::SMTA_EXEC: begin
        if (dir_q == `SMTA_DIR_READ) begin
          if (sel_q == `SMTA_SEL_MC) begin
            ent_d[`SMTA_MC_WORD] = mc_row;
          end else begin
            for (int i = 0; i < `SMTA_WORDS; i++) begin
              ent_d[i] = st_row[32*i +: 32];
            end
          end
        end else begin
          mc_we = (sel_q == `SMTA_SEL_MC);
          st_we = (sel_q != `SMTA_SEL_MC);
        end
        go_d    = 1'b0;
        state_d = smta_pkg::SMTA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q  <= smta_pkg::SMTA_IDLE;
      idx_q    <= '0;
      rsv_q    <= '0;
      go_q     <= 1'b0;
      sel_q    <= 1'b0;
      dir_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
      for (int i = 0; i < `SMTA_WORDS; i++) begin
        ent_q[i] <= 32'h0000_0000;
      end
    end else if (ce_i) begin
      state_q  <= state_d;
      idx_q    <= idx_d;
      rsv_q    <= rsv_d;
      go_q     <= go_d;
      sel_q    <= sel_d;
      dir_q    <= dir_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      ent_q    <= ent_d;
    end
  end

  // table memories
  always_ff @(posedge clk_i) begin
    if (ce_i && st_we) begin
      st_mem[st_idx] <= {ent_q[3], ent_q[2], ent_q[1], ent_q[0]};
    end
    if (ce_i && mc_we) begin
      mc_mem[mc_idx] <= ent_q[`SMTA_MC_WORD];
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign busy_o       = go_q;

  ctrl_go_set_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && wr_ok && reg_addr_i == `SMTA_CTRL_OFS
     && reg_wdata_i[`SMTA_GO_BIT]) |=> go_q)
    else $error("go not set by control write");

  go_self_clear_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    ($rose(go_q) && ce_i ##1 ce_i) |=> !go_q)
    else $error("go did not clear after access");

  mc_index_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && mc_we) |=> (mc_row == $past(ent_q[`SMTA_MC_WORD])))
    else $error("multicast entry not written at index");

  st_index_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && st_we) |=>
    (st_row == {$past(ent_q[3]), $past(ent_q[2]),
                $past(ent_q[1]), $past(ent_q[0])}))
    else $error("static entry not written at index");

  table_select_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (mc_we |-> sel_q) and (st_we |-> !sel_q))
    else $error("wrong table written");

  dir_write_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == smta_pkg::SMTA_EXEC) |-> ((st_we || mc_we) == !dir_q))
    else $error("write direction wrong");

  st_read_words_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && state_q == smta_pkg::SMTA_EXEC && dir_q && !sel_q) |=>
    ({ent_q[3], ent_q[2], ent_q[1], ent_q[0]} == $past(st_row)))
    else $error("static read did not fill entry words");

  mc_read_word_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (ce_i && state_q == smta_pkg::SMTA_EXEC && dir_q && sel_q) |=>
    (ent_q[1] == $past(mc_row) && ent_q[0] == $past(ent_q[0])
     && ent_q[2] == $past(ent_q[2]) && ent_q[3] == $past(ent_q[3])))
    else $error("multicast read touched other words");

  ce_freeze_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !ce_i |=> $stable(go_q) && $stable(ent_q[1]) && $stable(state_q))
    else $error("state moved with enable low");

endmodule
`default_nettype wire

// ==== tb/smta_top_test.sv ====
// self-checking bench for the table access register block
`timescale 1ns/10ps
`default_nettype none
`include "smta_cfg.svh"
module smta_top_test;
  logic                    clk_i = 1'b0;
  logic                    reset_i = 1'b1;
  logic                    ce_i = 1'b1;
  logic [`SMTA_ADDR_W-1:0] reg_addr_i = '0;
  logic                    reg_wr_i = 1'b0;
  logic                    reg_rd_i = 1'b0;
  logic [31:0]             reg_wdata_i = '0;
  logic [31:0]             reg_rdata_o;
  logic                    reg_rvalid_o;
  logic                    busy_o;
  int                      bad_count = 0;
  int                      num_checks = 0;

  smta_top smta_top_i (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .busy_o(busy_o));

  always #10 clk_i = ~clk_i;

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i) #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_i) #1;
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_i) #1;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_i) #1;
    reg_rd_i = 1'b0;
    cmp({31'h0, reg_rvalid_o}, 32'h0000_0001, "read answer");
    d = reg_rdata_o;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e,
                       input string msg);
    logic [31:0] d;
    rd(a, d);
    cmp(d, e, msg);
  endtask

  // starts an access and waits until the go bit drops
  task automatic go(input logic [5:0] idx, input logic sel, input logic dir);
    int i;
    wr(`SMTA_CTRL_OFS, {10'h0, idx, 8'h0, 1'b1, 5'h15, sel, dir});
    cmp({31'h0, busy_o}, 32'h0000_0001, "busy after go");
    for (i = 0; i < 20 && busy_o !== 1'b0; i++)
      @(posedge clk_i) #1;
    if (i == 20) begin
      cmp(32'h1, 32'h0, "access never finished");
      final_report();
    end
    rdchk(`SMTA_CTRL_OFS, {10'h0, idx, 8'h0, 1'b0, 5'h15, sel, dir},
          "control readback");
  endtask

  task automatic t_reset();
    int k;
    rdchk(`SMTA_CTRL_OFS, 32'h0, "control reset");
    for (k = 0; k < 4; k++)
      rdchk(`SMTA_ENT_BASE + 16'(k * 4), 32'h0, "entry reset");
    rdchk(16'h0418, 32'h0, "unmapped below");
    rdchk(16'h0430, 32'h0, "unmapped above");
    $display("test reset done");
  endtask

  task automatic t_static();
    int k;
    for (k = 0; k < 4; k++)
      wr(`SMTA_ENT_BASE + 16'(k * 4), 32'hA5A5_0000 + 32'(k));
    go(6'h25, 1'b0, 1'b0);
    for (k = 0; k < 4; k++)
      wr(`SMTA_ENT_BASE + 16'(k * 4), 32'h0);
    go(6'h05, 1'b0, 1'b1);
    for (k = 0; k < 4; k++)
      rdchk(`SMTA_ENT_BASE + 16'(k * 4), 32'hA5A5_0000 + 32'(k),
            "static entry");
    $display("test static done");
  endtask

  task automatic t_mcast();
    wr(`SMTA_ENT2_OFS, 32'hCAFE_0001);
    go(6'h3F, 1'b1, 1'b0);
    wr(`SMTA_ENT2_OFS, 32'h0000_BEEF);
    go(6'h1F, 1'b1, 1'b0);
    wr(`SMTA_ENT1_OFS, 32'h5555_AAAA);
    wr(`SMTA_ENT2_OFS, 32'h0);
    go(6'h3F, 1'b1, 1'b1);
    rdchk(`SMTA_ENT2_OFS, 32'hCAFE_0001, "mcast word");
    rdchk(`SMTA_ENT1_OFS, 32'h5555_AAAA, "word1 kept");
    rdchk(`SMTA_ENT3_OFS, 32'hA5A5_0002, "word3 kept");
    rdchk(`SMTA_ENT4_OFS, 32'hA5A5_0003, "word4 kept");
    rdchk(16'h0430, 32'h0, "unmapped after data");
    go(6'h05, 1'b0, 1'b1);
    rdchk(`SMTA_ENT2_OFS, 32'hA5A5_0001, "static after mcast");
    $display("test mcast done");
  endtask

  // access held by a low enable, then a write refused while busy
  task automatic t_freeze();
    wr(`SMTA_ENT2_OFS, 32'h1234_5678);
    wr(`SMTA_CTRL_OFS, {10'h0, 6'h2A, 8'h0, 1'b1, 5'h00, 1'b1, 1'b0});
    ce_i = 1'b0;
    repeat (4) @(posedge clk_i) #1;
    cmp({31'h0, busy_o}, 32'h0000_0001, "busy held while frozen");
    ce_i = 1'b1;
    wr(`SMTA_ENT2_OFS, 32'hDEAD_0000);
    cmp({31'h0, busy_o}, 32'h0000_0000, "busy after frozen access");
    rdchk(`SMTA_ENT2_OFS, 32'h1234_5678, "write refused while busy");
    wr(`SMTA_ENT2_OFS, 32'h0);
    go(6'h2A, 1'b1, 1'b1);
    rdchk(`SMTA_ENT2_OFS, 32'h1234_5678, "frozen access landed");
    $display("test freeze done");
  endtask

  // second reset in mid-run clears control and entry words
  task automatic t_rerun();
    reset_i = 1'b1;
    repeat (2) @(posedge clk_i) #1;
    reset_i = 1'b0;
    cmp({31'h0, busy_o}, 32'h0000_0000, "busy after reset");
    rdchk(`SMTA_CTRL_OFS, 32'h0, "control after reset");
    rdchk(`SMTA_ENT2_OFS, 32'h0, "entry after reset");
    $display("test rerun done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_static();
    t_mcast();
    t_freeze();
    t_rerun();
    final_report();
  end
endmodule
`default_nettype wire
